// *** hdl/status_summary_regs.vh ***
/*
 * Status summary block constants: bit positions, reset values and
 * command codes of the host command port.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef STATUS_SUMMARY_REGS_VH
`define STATUS_SUMMARY_REGS_VH

// Summary byte bit positions
`define SUM_BIT_UNUSED 0
`define SUM_BIT_DEVICE 1
`define SUM_BIT_ERRQ 2
`define SUM_BIT_SUSPECT 3
`define SUM_BIT_MSG 4
`define SUM_BIT_EVENT 5
`define SUM_BIT_REQ 6
`define SUM_BIT_OPER 7

// Reset values
`define REQ_MASK_RESET 8'h00
`define EVT_MASK_RESET 8'h00
`define EVT_LATCH_RESET 8'h00

// Command codes on the host command port
`define CMD_NONE 3'h0
`define CMD_WR_REQ_MASK 3'h1
`define CMD_RD_REQ_MASK 3'h2
`define CMD_RD_SUMMARY 3'h3
`define CMD_WR_EVT_MASK 3'h4
`define CMD_RD_EVT_MASK 3'h5
`define CMD_RD_EVT_LATCH 3'h6
`define CMD_RD_ERR_COUNT 3'h7

`endif

// *** hdl/sync_bits.v ***
/*
 * Two-stage synchroniser for a bus of independent level bits.
 * Assumes each bit is a slow level from outside the mclk domain.
 */
`timescale 1ns/10ps
module sync_bits #(
    parameter WIDTH = 8
) (
    input wire mclk,
    input wire rst_n,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

reg [WIDTH-1:0] stage1_r;
reg [WIDTH-1:0] stage2_r;

////////////////////////////////////////////////////////////////////////
genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_sync
        always @(posedge mclk) begin
            if (!rst_n) begin
                stage1_r[i] <= 1'b0;
                stage2_r[i] <= 1'b0;
            end else begin
                stage1_r[i] <= asyncIn[i];
                stage2_r[i] <= stage1_r[i];
            end
        end
    end
endgenerate

assign syncOut = stage2_r;

endmodule // sync_bits

// *** hdl/status_byte_service_request.v ***
/*
 * Top of the status reporting hierarchy: builds the 8-bit status
 * summary byte, the request enable mask, the standard event latch and
 * mask, and raises the request pending summary.
 * Assumes lower group summaries, error queue count and message flag
 * arrive as levels from other clock domains; event pulses and the
 * command port are on mclk. A command decoder upstream turns the
 * text commands into cmdValid/cmdCode/cmdData.
 */
//
// Function
// - Summary byte paired with request enable mask
// - Bit 1 follows device status group summary
// - Bit 2 set while error queue nonempty
// - Each new error entry raises request while mask bit 2 is set
// - Bit 3 follows enabled suspect-state events
// - Bit 4 set while response message waits
// - Bit 5 from latch masked by mask
// - Bit 6 any enabled summary bit set
// - Bit 7 follows enabled operation events
// - Request enable mask writable and readable
// - Status and error count readable by query
// - Standard event mask writable, readable, gates bit5
// - Standard event latch readable, clears on read
`timescale 1ns/10ps
`include "status_summary_regs.vh"
module status_byte_service_request #(
    parameter ERR_COUNT_WIDTH = 5
) (
    input wire mclk,
    input wire rst_n,
    input wire deviceSummary,
    input wire suspectSummary,
    input wire operationSummary,
    input wire messageWaiting,
    input wire [ERR_COUNT_WIDTH-1:0] errorCount,
    input wire [7:0] eventSet,
    input wire cmdValid,
    input wire [2:0] cmdCode,
    input wire [7:0] cmdData,
    output reg [7:0] rspData,
    output reg rspValid,
    output reg [7:0] serviceStatusSummary,
    output reg serviceRequest
);

////////////////////////////////////////////////////////////////////////
// Input synchronisers

wire [ERR_COUNT_WIDTH+3:0] syncIn;
wire devSync;
wire susSync;
wire operSync;
wire msgSync;
wire [ERR_COUNT_WIDTH-1:0] errCntSync;

sync_bits #(
    .WIDTH(ERR_COUNT_WIDTH + 4)
) uSync (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn({errorCount, messageWaiting, operationSummary,
        suspectSummary, deviceSummary}),
    .syncOut(syncIn)
);

assign devSync = syncIn[0];
assign susSync = syncIn[1];
assign operSync = syncIn[2];
assign msgSync = syncIn[3];
assign errCntSync = syncIn[ERR_COUNT_WIDTH+3:4];

////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] requestEnableMask_r;
reg [7:0] eventMask_r;
reg [7:0] eventLatch_r;
reg [ERR_COUNT_WIDTH-1:0] errCountPrev_r;
reg [ERR_COUNT_WIDTH-1:0] errCntLast_r;
reg [ERR_COUNT_WIDTH-1:0] errCntHold_r;
reg errNewPend_r;
reg [7:0] sumNxt;
reg reqNxt;
reg [7:0] latchNxt;
wire errNew;
wire latchRead;

assign errNew = (errCntHold_r > errCountPrev_r);
assign latchRead = cmdValid && (cmdCode == `CMD_RD_EVT_LATCH);

////////////////////////////////////////////////////////////////////////
// Summary byte assembly

always @* begin
    sumNxt = 8'h00;
    sumNxt[`SUM_BIT_UNUSED] = 1'b0;
    sumNxt[`SUM_BIT_DEVICE] = devSync;
    sumNxt[`SUM_BIT_ERRQ] = |errCntHold_r;
    sumNxt[`SUM_BIT_SUSPECT] = susSync;
    sumNxt[`SUM_BIT_MSG] = msgSync;
    sumNxt[`SUM_BIT_EVENT] = |(eventLatch_r & eventMask_r);
    sumNxt[`SUM_BIT_OPER] = operSync;
    // request pending from enabled bits, bit 0 and 6 excluded
    reqNxt = |(sumNxt & requestEnableMask_r & 8'hBE);
    // a fresh error entry requests even if bit 2 already set
    if (requestEnableMask_r[`SUM_BIT_ERRQ] && (errNewPend_r || errNew)) begin
        reqNxt = 1'b1;
    end
    sumNxt[`SUM_BIT_REQ] = reqNxt;
end

always @* begin
    latchNxt = latchRead ? 8'h00 : eventLatch_r;
    latchNxt = latchNxt | eventSet;
end

////////////////////////////////////////////////////////////////////////
// Sequential state

always @(posedge mclk) begin
    if (!rst_n) begin
        requestEnableMask_r <= `REQ_MASK_RESET;
        eventMask_r <= `EVT_MASK_RESET;
        eventLatch_r <= `EVT_LATCH_RESET;
        errCountPrev_r <= {ERR_COUNT_WIDTH{1'b0}};
        errCntLast_r <= {ERR_COUNT_WIDTH{1'b0}};
        errCntHold_r <= {ERR_COUNT_WIDTH{1'b0}};
        errNewPend_r <= 1'b0;
        serviceStatusSummary <= 8'h00;
        serviceRequest <= 1'b0;
    end else begin
        eventLatch_r <= latchNxt;
        // Count word may be caught mid-change; take it once two agree
        errCntLast_r <= errCntSync;
        if (errCntSync == errCntLast_r) begin
            errCntHold_r <= errCntSync;
        end
        errCountPrev_r <= errCntHold_r;
        // New error pulse held one cycle so the request edge is seen
        errNewPend_r <= errNew;
        serviceStatusSummary <= sumNxt;
        serviceRequest <= reqNxt;
        if (cmdValid) begin
            case (cmdCode)
                `CMD_WR_REQ_MASK: begin
                    requestEnableMask_r <= cmdData;
                end
                `CMD_WR_EVT_MASK: begin
                    eventMask_r <= cmdData;
                end
                default: begin
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Query answers, one cycle after the command

always @(posedge mclk) begin
    if (!rst_n) begin
        rspData <= 8'h00;
        rspValid <= 1'b0;
    end else begin
        rspValid <= 1'b0;
        if (cmdValid) begin
            case (cmdCode)
                `CMD_RD_REQ_MASK: begin
                    rspData <= requestEnableMask_r;
                    rspValid <= 1'b1;
                end
                `CMD_RD_SUMMARY: begin
                    rspData <= serviceStatusSummary;
                    rspValid <= 1'b1;
                end
                `CMD_RD_EVT_MASK: begin
                    rspData <= eventMask_r;
                    rspValid <= 1'b1;
                end
                `CMD_RD_EVT_LATCH: begin
                    rspData <= eventLatch_r;
                    rspValid <= 1'b1;
                end
                `CMD_RD_ERR_COUNT: begin
                    rspData <= {{(8-ERR_COUNT_WIDTH){1'b0}}, errCntHold_r};
                    rspValid <= 1'b1;
                end
                default: begin
                    rspValid <= 1'b0;
                end
            endcase
        end
    end
end

endmodule // status_byte_service_request

// *** tb/status_byte_service_request_assertions.sv ***
/* Port checker for the status summary block.
   Assumes binding onto status_byte_service_request. */
`timescale 1ns/10ps
module status_byte_service_request_assertions #(
    parameter ERR_COUNT_WIDTH = 5
) (
    input wire mclk,
    input wire rst_n,
    input wire messageWaiting,
    input wire [ERR_COUNT_WIDTH-1:0] errorCount,
    input wire [7:0] eventSet,
    input wire cmdValid,
    input wire [2:0] cmdCode,
    input wire [7:0] cmdData,
    input wire [7:0] rspData,
    input wire rspValid,
    input wire [7:0] serviceStatusSummary,
    input wire serviceRequest
);
    wire isRd = cmdValid && (cmdCode[1] || cmdCode == 3'h5);
    wire [7:0] ssb = serviceStatusSummary;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    reg [7:0] maskShadow_r;
    // Copy of the request enable mask seen from the command port
    always @(posedge mclk) begin
        if (!rst_n) begin
            maskShadow_r <= 8'h00;
        end else if (cmdValid && cmdCode == 3'h1) begin
            maskShadow_r <= cmdData;
        end
    end
    property p_zero; !ssb[0]; endproperty
    a_zero: assert property (p_zero) else $error("bit0 set");
    property p_req; serviceRequest == ssb[6]; endproperty
    a_req: assert property (p_req) else $error("req");
    property p_req_set;
        |(ssb & $past(maskShadow_r) & 8'hbe) |-> ssb[6];
    endproperty
    a_req_set: assert property (p_req_set) else $error("req mask");
    property p_ans; isRd |=> rspValid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_quiet; !isRd |=> !rspValid; endproperty
    a_quiet: assert property (p_quiet) else $error("stray");
    property p_mask; cmdValid && cmdCode == 3'h1 ##1 cmdValid &&
        cmdCode == 3'h2 |=> rspData == $past(cmdData, 2); endproperty
    a_mask: assert property (p_mask) else $error("mask");
    property p_err; (|errorCount)[*6] |-> ssb[2]; endproperty
    a_err: assert property (p_err) else $error("err");
    property p_msg; messageWaiting[*5] |-> ssb[4]; endproperty
    a_msg: assert property (p_msg) else $error("msg");
    property p_latch; cmdValid && cmdCode == 3'h6 && eventSet == 8'h00
        ##1 cmdValid && cmdCode == 3'h6 |=> rspData == 8'h00; endproperty
    a_latch: assert property (p_latch) else $error("latch");
    c_req: cover property (rspValid && serviceRequest);
    c_evt: cover property (ssb[5]);
    c_err: cover property (ssb[2] && ssb[4]);
endmodule // status_byte_service_request_assertions
bind status_byte_service_request status_byte_service_request_assertions #(
    .ERR_COUNT_WIDTH(ERR_COUNT_WIDTH)
) chk (.mclk(mclk), .rst_n(rst_n), .messageWaiting(messageWaiting),
    .errorCount(errorCount), .eventSet(eventSet), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdData(cmdData), .rspData(rspData),
    .rspValid(rspValid), .serviceStatusSummary(serviceStatusSummary),
    .serviceRequest(serviceRequest));

// *** tb/host_model.sv ***
/* Host model issuing status commands.
   Assumes one caller process. */
`timescale 1ns/10ps
module host_model (
    input wire mclk,
    output reg cmdValid,
    output reg [2:0] cmdCode,
    output reg [7:0] cmdData
);
    initial begin
        cmdValid = 1'h0;
        cmdCode = 3'h0;
        cmdData = 8'h00;
    end
    task send(input [2:0] c, input [7:0] d);
        @(posedge mclk);
        cmdValid <= 1'h1;
        cmdCode <= c;
        cmdData <= d;
    endtask
    task idle();
        @(posedge mclk);
        cmdValid <= 1'h0;
        cmdData <= ~cmdData;
    endtask
endmodule // host_model

// *** tb/tb.sv ***
/* Bench for the status summary block.
   Assumes host_model drives commands. */
`timescale 1ns/10ps
module tb;
    reg mclk = 1'h0;
    reg rst_n = 1'h0;
    reg dev = 1'h0, sus = 1'h0, opr = 1'h0, msg = 1'h0;
    reg [4:0] errCnt = 5'h00;
    reg [7:0] evt = 8'h00, latch = 8'h00, reqMask, evtMask, e;
    reg [31:0] seed = 32'hb64a, r;
    reg up;
    wire cmdValid, rspValid, srq;
    wire [2:0] cmdCode;
    wire [7:0] cmdData, rspData, sum;
    reg [7:0] expq[$];
    integer errors = 0, tests_run = 0, i;
    always #4 mclk = ~mclk;
    host_model host (.mclk(mclk), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdData(cmdData));
    status_byte_service_request uut (.mclk(mclk), .rst_n(rst_n),
        .deviceSummary(dev), .suspectSummary(sus), .operationSummary(opr),
        .messageWaiting(msg), .errorCount(errCnt), .eventSet(evt),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData),
        .rspData(rspData), .rspValid(rspValid),
        .serviceStatusSummary(sum), .serviceRequest(srq));
    function [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction
    task cmp(input [7:0] got, input [7:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rd(input [2:0] c, input [7:0] x);
        expq.push_back(x);
        host.send(c, x ^ 8'h5a);
    endtask
    task final_report();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////
    always @(posedge mclk) if (rspValid === 1'h1) begin
        if (expq.size() == 0)
            expq.push_back(8'hxx);
        cmp(rspData, expq.pop_front());
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'h1;
        for (i = 0; i < 8; i = i + 1) begin
            r = rnd();
            up = r[28] | i[0];
            reqMask = r[7:0] | {5'h00, i[0], 2'h0};
            evtMask = r[15:8];
            host.send(3'h1, reqMask);
            rd(3'h2, reqMask);
            host.send(3'h4, evtMask);
            rd(3'h5, evtMask);
            host.idle();
            evt <= r[23:16];
            latch = latch | r[23:16];
            @(posedge mclk);
            evt <= 8'h00;
            {dev, sus, opr, msg} <= r[27:24];
            errCnt <= up ? errCnt + 5'h01 :
                errCnt - {4'h0, errCnt != 5'h00};
            repeat (6) @(posedge mclk);
            if (reqMask[2] && up)
                cmp({7'h00, srq}, 8'h01);
            repeat (2) @(posedge mclk);
            e = {opr, 1'h0, |(latch & evtMask), msg, sus,
                errCnt != 5'h00, dev, 1'h0};
            e[6] = |(e & reqMask & 8'hbe);
            cmp({7'h00, srq}, {7'h00, e[6]});
            cmp(sum, e);
            rd(3'h3, e);
            rd(3'h6, latch);
            latch = 8'h00;
            rd(3'h6, 8'h00);
            rd(3'h7, {3'h0, errCnt});
            host.send(3'h0, r[31:24]);
            host.idle();
        end
        repeat (4) @(posedge mclk);
        if (expq.size() != 0)
            errors = errors + 1;
        final_report();
    end
endmodule // tb
